//--- dv/asr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host_model #(
  parameter int unsigned CS_HOLD = 200
) (
  // system
  input wire logic sys_clk,
  // serial link
  input wire logic dout,
  output logic cs_n,
  output logic sclk,
  output logic din
);
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
  end
  // ****
  // one whole transaction of n clocks
  // ****
  task automatic xfer(input int n, input int half, input logic [7:0] tx, output logic flag,
                      output logic [95:0] rx);
    rx = '0;
    @(posedge sys_clk) cs_n <= 1'b0;
    repeat (3) @(posedge sys_clk);
    flag = dout;
    for (int i = 0; i < n; i++) begin
      sclk <= 1'b1;
      din <= (i < 8) ? tx[7 - i] : 1'b0;
      repeat (half - 1) @(posedge sys_clk);
      rx = {rx[94:0], dout};
      @(posedge sys_clk) sclk <= 1'b0;
      repeat (half) @(posedge sys_clk);
    end
    repeat (CS_HOLD) @(posedge sys_clk);
    cs_n <= 1'b1;
  endtask
endmodule
`default_nettype wire

//--- dv/asr_readout_port_properties.sv
`timescale 1ns/1ps
`default_nettype none
module asr_rp_props (
  // system
  input wire logic SYS_CLK,
  input wire logic RST,
  // clocking
  input wire logic CLOCK_SOURCE_SELECT_PIN,
  input wire logic CLK_OUT_EN,
  input wire logic CLK_PIN_I,
  input wire logic CLK_PIN_O,
  input wire logic CLK_PIN_OE,
  input wire logic MOD_CLK_TICK,
  // configuration
  input wire logic [7:0] LEAD_OFF_STATUS_REGISTER,
  input wire logic REF_BUFFER_ENABLE,
  input wire logic HIGH_REFERENCE_SELECT,
  input wire logic REFERENCE_BUFFER_POWER_DOWN,
  input wire logic REF_HIGH_LEVEL,
  // serial link
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DOUT_O,
  input wire logic DOUT_OE,
  input wire logic CONVERSION_READY_N
);
  // ****
  // device clock rises between ticks
  // ****
  logic dclk, rise, dclk_q, armed, cfg_q;
  logic [5:0] rises;
  assign dclk = CLOCK_SOURCE_SELECT_PIN ? CLK_PIN_O : CLK_PIN_I;
  assign rise = dclk && !dclk_q;
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      dclk_q <= 1'b0;
      rises <= 6'h00;
      armed <= 1'b0;
      cfg_q <= 1'b0;
    end else begin
      dclk_q <= dclk;
      cfg_q <= LEAD_OFF_STATUS_REGISTER[6] ^ CLOCK_SOURCE_SELECT_PIN;
      rises <= MOD_CLK_TICK ? {5'h00, rise} : rises + {5'h00, rise};
      armed <= (cfg_q == (LEAD_OFF_STATUS_REGISTER[6] ^ CLOCK_SOURCE_SELECT_PIN)) && (armed || MOD_CLK_TICK);
    end
  end
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  clk_pin_oe_a: assert property (
    CLK_PIN_OE == (CLOCK_SOURCE_SELECT_PIN && CLK_OUT_EN)) else $error("clock pin enable wrong");
  tick_div_a: assert property (
    MOD_CLK_TICK && armed && (CLK_PIN_OE || !CLOCK_SOURCE_SELECT_PIN)
    |-> rises == (LEAD_OFF_STATUS_REGISTER[6] ? 6'h10 : 6'h04)) else $error("modulator divide wrong");
  tick_pulse_a: assert property (
    MOD_CLK_TICK |=> !MOD_CLK_TICK [*2]) else $error("modulator tick too close");
  ref_pd_a: assert property (
    REFERENCE_BUFFER_POWER_DOWN == !$past(REF_BUFFER_ENABLE)) else $error("buffer power down wrong");
  ref_high_a: assert property (
    REF_HIGH_LEVEL == $past(HIGH_REFERENCE_SELECT)) else $error("reference level wrong");
  dout_float_a: assert property (
    DOUT_OE == !CS_N) else $error("data output enable wrong");
  ready_release_a: assert property (
    !CONVERSION_READY_N && $fell(SCLK) |-> ##[1:3] CONVERSION_READY_N) else $error("ready not released");
  dout_hold_a: assert property (
    !CS_N && $fell(SCLK) |-> $stable(DOUT_O)) else $error("data output moved off rise");
  cover property (MOD_CLK_TICK && armed && LEAD_OFF_STATUS_REGISTER[6]);
  cover property (!CONVERSION_READY_N && $fell(SCLK));
  cover property (MOD_CLK_TICK && armed && !CLOCK_SOURCE_SELECT_PIN);
endmodule
bind asr_readout_port asr_rp_props asr_rp_props_inst (.SYS_CLK(SYS_CLK), .RST(RST),
  .CLOCK_SOURCE_SELECT_PIN(CLOCK_SOURCE_SELECT_PIN), .CLK_OUT_EN(CLK_OUT_EN), .CLK_PIN_I(CLK_PIN_I),
  .CLK_PIN_O(CLK_PIN_O), .CLK_PIN_OE(CLK_PIN_OE), .MOD_CLK_TICK(MOD_CLK_TICK),
  .LEAD_OFF_STATUS_REGISTER(LEAD_OFF_STATUS_REGISTER), .REF_BUFFER_ENABLE(REF_BUFFER_ENABLE),
  .HIGH_REFERENCE_SELECT(HIGH_REFERENCE_SELECT), .REFERENCE_BUFFER_POWER_DOWN(REFERENCE_BUFFER_POWER_DOWN),
  .REF_HIGH_LEVEL(REF_HIGH_LEVEL), .CS_N(CS_N), .SCLK(SCLK), .DOUT_O(DOUT_O), .DOUT_OE(DOUT_OE),
  .CONVERSION_READY_N(CONVERSION_READY_N));
`default_nettype wire

//--- dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk, rst, sel, clk_out_en, ref_en, ref_high, cont_mode, rd_cmd, s_valid, s_ready, flag;
  logic cs_n, sclk, din, dout_o, dout_oe, dout_last, ready_n, mod_tick, pd_out, rx_valid;
  logic [7:0] loff, rx_byte, got_byte;
  logic [1:0] gpio, ch_pd, pd;
  logic [19:0] raw1, raw2, a, c;
  logic [2:0] ext_cnt;
  logic [31:0] rnd;
  logic [47:0] e;
  logic [95:0] rx;
  logic [47:0] exp_q[$];
  logic [19:0] corner[8] = '{20'h7ffff, 20'h80000, 20'h00000, 20'h00001, 20'hfffff, 20'h07fff,
    20'hf8000, 20'h08000};
  int err_count = 0;
  int n_tests = 0;
  wire logic dout_line;
  assign dout_line = dout_oe ? dout_o : ~dout_last;
  asr_readout_port asr_readout_port_inst (.SYS_CLK(sys_clk), .RST(rst), .CLOCK_SOURCE_SELECT_PIN(sel),
    .CLK_OUT_EN(clk_out_en), .CLK_PIN_I(ext_cnt[2]), .CLK_PIN_O(), .CLK_PIN_OE(), .MOD_CLK_TICK(mod_tick),
    .LEAD_OFF_STATUS_REGISTER(loff), .GPIO_LEVEL(gpio), .CH_POWER_DOWN(ch_pd), .REF_BUFFER_ENABLE(ref_en),
    .HIGH_REFERENCE_SELECT(ref_high), .REFERENCE_BUFFER_POWER_DOWN(pd_out), .REF_HIGH_LEVEL(),
    .CONTINUOUS_READ_MODE(cont_mode), .FRAME_READ_CMD(rd_cmd), .SAMPLE_VALID(s_valid),
    .SAMPLE_READY(s_ready), .CH1_RAW(raw1), .CH2_RAW(raw2), .CS_N(cs_n), .SCLK(sclk), .DIN(din),
    .DOUT_O(dout_o), .DOUT_OE(dout_oe), .CONVERSION_READY_N(ready_n), .RX_BYTE(rx_byte),
    .RX_BYTE_VALID(rx_valid));
  asr_host_model asr_host_model_inst (.sys_clk(sys_clk), .dout(dout_line), .cs_n(cs_n), .sclk(sclk),
    .din(din));
  // ****
  // helpers
  // ****
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    for (int i = 0; i < 8; i++) s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    return s;
  endfunction
  function automatic logic [15:0] sat(input logic [19:0] r);
    if ($signed(r) > $signed(20'h07fff)) return 16'h7fff;
    if ($signed(r) < $signed(20'hf8000)) return 16'h8000;
    return r[15:0];
  endfunction
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic wait_for(input logic tick);
    for (int i = 0; i < 4000; i++) begin
      @(negedge sys_clk);
      if (tick ? (mod_tick === 1'b1) : (ready_n === 1'b0)) begin
        @(posedge sys_clk);
        return;
      end
    end
    err_count++;
    give_verdict();
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) ext_cnt <= ext_cnt + 3'h1;
  always @(posedge sys_clk) if (dout_oe) dout_last <= dout_o;
  always @(negedge sys_clk) if (rx_valid === 1'b1) got_byte = rx_byte;
  // ****
  // main sequence
  // ****
  initial begin
    {rst, sel, clk_out_en, ref_en, ref_high, cont_mode, rd_cmd, s_valid} = 8'h80;
    {loff, gpio, ch_pd, raw1, raw2, dout_last, ext_cnt, got_byte} = '0;
    rnd = 32'h0000000f;
    repeat (20) @(posedge sys_clk);
    @(negedge sys_clk);
    check({46'h0, pd_out, dout_oe}, 48'h2);
    @(posedge sys_clk) rst <= 1'b0;
    for (int b = 0; b < 2; b++) begin
      rnd = lfsr(rnd);
      sel <= (b == 0);
      clk_out_en <= (b == 0) | rnd[0];
      loff <= {1'b0, b[0], 1'b0, rnd[12:8]};
      gpio <= rnd[14:13];
      ref_en <= rnd[15];
      ref_high <= rnd[16];
      wait_for(1'b1);
      wait_for(1'b1);
      for (int i = 0; i < 8; i++) begin
        rnd = lfsr(rnd);
        a = (b == 0) ? corner[i] : (rnd[31] ? {{4{rnd[15]}}, rnd[15:0]} : rnd[19:0]);
        c = (b == 0) ? corner[7 - i] : rnd[30:11];
        pd = rnd[7:6] & rnd[5:4];
        exp_q.push_back({4'hc, loff[4:0], gpio, 5'h00, pd[0] ? 16'h0000 : sat(a), pd[1] ? 16'h0000 : sat(c)});
        s_valid <= 1'b1;
        raw1 <= a;
        raw2 <= c;
        ch_pd <= pd;
        @(posedge sys_clk);
      end
      @(negedge sys_clk);
      check({47'h0, s_ready}, 48'h0);
      @(posedge sys_clk) s_valid <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        wait_for(1'b0);
        cont_mode <= i[0];
        rd_cmd <= !i[0];
        @(posedge sys_clk) rd_cmd <= 1'b0;
        asr_host_model_inst.xfer((i == 1) ? 96 : 48, 4, 8'h00, flag, rx);
        e = exp_q.pop_front();
        check({47'h0, flag}, 48'h0);
        check(rx[47:0], e);
        if (i == 1) check(rx[95:48], e);
      end
      $display("batch %0d done", b);
    end
    rnd = lfsr(rnd);
    asr_host_model_inst.xfer(8, 13, rnd[7:0], flag, rx);
    check({40'h0, got_byte}, {40'h0, rnd[7:0]});
    $display("command byte done");
    give_verdict();
  end
endmodule
`default_nettype wire

//--- src/asr_fifo.sv
`timescale 1ns/1ps
`default_nettype none

module asr_fifo #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
  } asr_fifo_s;

  asr_fifo_s st_reg;
  asr_fifo_s st_next;
  logic push;
  logic pop;

  // ********************************
  // handshakes
  // ********************************
  assign in_ready = (st_reg.count != (AW+1)'(DEPTH));
  assign out_valid = (st_reg.count != '0);
  assign out_data = st_reg.mem[st_reg.rd_ptr];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // ********************************
  // pointers and storage
  // ********************************
  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr_ptr] = in_data;
      st_next.wr_ptr = (st_reg.wr_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.wr_ptr + 1'b1;
    end
    if (pop) begin
      st_next.rd_ptr = (st_reg.rd_ptr == AW'(DEPTH - 1)) ? '0 : st_reg.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      st_next.count = st_reg.count + 1'b1;
    end else if (pop && !push) begin
      st_next.count = st_reg.count - 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

`default_nettype wire

//--- src/asr_pkg.sv
package asr_pkg;

  // ********************************
  // clocking
  // ********************************
  localparam int unsigned SYS_CLK_HZ = 25_000_000;
  localparam int unsigned OSC_HZ = 512_000;
  localparam int unsigned OSC_HALF_CYC = SYS_CLK_HZ / (2 * OSC_HZ);
  localparam int unsigned EXT_CLK_SLOW_HZ = 512_000;
  localparam int unsigned EXT_CLK_FAST_HZ = 2_048_000;
  localparam int unsigned MOD_HZ = 128_000;
  localparam logic [4:0] MOD_DIV_SLOW = 5'(EXT_CLK_SLOW_HZ / MOD_HZ);
  localparam logic [4:0] MOD_DIV_FAST = 5'(EXT_CLK_FAST_HZ / MOD_HZ);

  // ********************************
  // lead-off status register fields
  // ********************************
  localparam int unsigned LOFF_CLK_DIV_BIT = 6;
  localparam int unsigned LEAD_OFF_STATUS_REGISTER_MSB = 4;

  // ********************************
  // frame layout
  // ********************************
  localparam int unsigned SAMPLE_W = 16;
  localparam int unsigned RAW_W = 20;
  localparam int unsigned NUM_CH = 2;
  localparam int unsigned FRAME_W = 48;
  localparam logic [3:0] STATUS_PREFIX = 4'hc;
  localparam logic [4:0] STATUS_PAD = 5'h00;
  localparam logic [15:0] SAMPLE_POS_FS = 16'h7fff;
  localparam logic [15:0] SAMPLE_NEG_FS = 16'h8000;
  localparam logic [15:0] SAMPLE_ZERO = 16'h0000;
  localparam int unsigned FIFO_DEPTH = 8;

  // ********************************
  // reset values
  // ********************************
  localparam logic READY_N_RST = 1'b1;
  localparam logic REF_BUF_PD_RST = 1'b1;

  // ********************************
  // serial link states
  // ********************************
  typedef enum logic [0:0] {
    ASR_LINK_IDLE,
    ASR_LINK_SHIFT
  } asr_link_e;

endpackage

//--- src/asr_readout_port.sv
// Summary of operation
// - clock source pin low: external clock in; high: oscillator, pin driven if enabled
// - external clock 512 kHz or 2.048 MHz, chosen by bit 6 of lead-off status
// - modulator clock is 128 kHz for either external clock rate
// - modulator clock is device clock over 4, or over 16 with divider bit set
// - after wake-up reference buffer stays powered down until software enables it
// - high reference select picks 4.033 V, otherwise 2.42 V
// - samples are 16-bit two's complement, sent most significant bit first
// - samples saturate at 7FFFh and 8000h beyond full scale
// - chip select high resets serial state, ignores data, floats output; a falling clock edge still releases conversion-ready
// - conversion-ready asserts at end of conversion unless a frame is still shifting with chip select low
// - input data sampled on every falling serial clock edge
// - output updated on every rising edge, first rising edge gives the MSB
// - conversion-ready returns high on first falling serial clock edge of a read
// - in continuous read mode the data output also flags new data
// - continuous streaming read and single on-demand frame read are both supported
// - a frame is 48 bits: status word then two 16-bit samples
// - status word is 1100, five lead-off bits, two gpio bits, five zeros
// - a powered-down channel sends all zeros but keeps its slot
// - clocking past the frame end repeats the frame from its MSB
`timescale 1ns/1ps
`default_nettype none

module asr_readout_port (
  // system
  input wire logic SYS_CLK,
  input wire logic RST,
  // clock pin and clock configuration
  input wire logic CLOCK_SOURCE_SELECT_PIN,
  input wire logic CLK_OUT_EN,
  input wire logic CLK_PIN_I,
  output logic CLK_PIN_O,
  output logic CLK_PIN_OE,
  output logic MOD_CLK_TICK,
  // configuration
  input wire logic [7:0] LEAD_OFF_STATUS_REGISTER,
  input wire logic [1:0] GPIO_LEVEL,
  input wire logic [1:0] CH_POWER_DOWN,
  input wire logic REF_BUFFER_ENABLE,
  input wire logic HIGH_REFERENCE_SELECT,
  output logic REFERENCE_BUFFER_POWER_DOWN,
  output logic REF_HIGH_LEVEL,
  // read mode control
  input wire logic CONTINUOUS_READ_MODE,
  input wire logic FRAME_READ_CMD,
  // raw samples from the filters
  input wire logic SAMPLE_VALID,
  output logic SAMPLE_READY,
  input wire logic [19:0] CH1_RAW,
  input wire logic [19:0] CH2_RAW,
  // serial link
  input wire logic CS_N,
  input wire logic SCLK,
  input wire logic DIN,
  output logic DOUT_O,
  output logic DOUT_OE,
  output logic CONVERSION_READY_N,
  // received command bytes
  output logic [7:0] RX_BYTE,
  output logic RX_BYTE_VALID
);

  localparam int unsigned SW = asr_pkg::SAMPLE_W;
  localparam int unsigned RW = asr_pkg::RAW_W;
  localparam int unsigned FW = asr_pkg::FRAME_W;

  typedef struct packed {
    logic sclk_prev;
    logic clk_pin_prev;
    logic [5:0] osc_cnt;
    logic osc_level;
    logic [4:0] mod_cnt;
    logic mod_tick;
    logic [FW-1:0] frame;
    logic [5:0] bit_ptr;
    logic dout;
    asr_pkg::asr_link_e link;
    logic single_armed;
    logic ready_n;
    logic release_done;
    logic [7:0] rx_shift;
    logic [2:0] rx_cnt;
    logic [7:0] rx_byte;
    logic rx_valid;
    logic ref_buf_pd;
    logic ref_high;
  } asr_state_s;

  asr_state_s st_reg;
  asr_state_s st_next;

  // ********************************
  // sample conditioning
  // ********************************
  function automatic logic [15:0] asr_saturate(input logic [19:0] raw);
    logic [15:0] res;
    res = raw[15:0];
    if (!raw[RW-1] && (raw[RW-2:SW-1] != '0)) begin
      res = asr_pkg::SAMPLE_POS_FS;
    end else if (raw[RW-1] && (raw[RW-2:SW-1] != '1)) begin
      res = asr_pkg::SAMPLE_NEG_FS;
    end
    return res;
  endfunction

  logic [1:0][15:0] ch_word;
  logic [19:0] ch_raw [2];
  assign ch_raw[0] = CH1_RAW;
  assign ch_raw[1] = CH2_RAW;

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ch
      // powered-down channel keeps its slot with zeros
      assign ch_word[gi] = CH_POWER_DOWN[gi] ? asr_pkg::SAMPLE_ZERO : asr_saturate(ch_raw[gi]);
    end
  endgenerate

  // ********************************
  // sample buffer
  // ********************************
  logic fifo_valid;
  logic fifo_pop;
  logic [31:0] fifo_data;

  asr_fifo #(
    .WIDTH(32),
    .DEPTH(asr_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk(SYS_CLK),
    .rst(RST),
    .in_valid(SAMPLE_VALID),
    .in_ready(SAMPLE_READY),
    .in_data({ch_word[0], ch_word[1]}),
    .out_valid(fifo_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_data)
  );

  // ********************************
  // edge detection and clock selection
  // ********************************
  logic sclk_rise;
  logic sclk_fall;
  logic ext_rise;
  logic osc_rise;
  logic dev_tick;
  logic clk_div_fast;
  logic [4:0] mod_div;
  logic conv_done;
  logic [15:0] status_word;

  assign sclk_rise = SCLK && !st_reg.sclk_prev;
  assign sclk_fall = !SCLK && st_reg.sclk_prev;
  assign ext_rise = CLK_PIN_I && !st_reg.clk_pin_prev;
  assign osc_rise = (st_reg.osc_cnt == 6'(asr_pkg::OSC_HALF_CYC - 1)) && !st_reg.osc_level;
  assign dev_tick = CLOCK_SOURCE_SELECT_PIN ? osc_rise : ext_rise;
  assign clk_div_fast = LEAD_OFF_STATUS_REGISTER[asr_pkg::LOFF_CLK_DIV_BIT];
  assign mod_div = clk_div_fast ? asr_pkg::MOD_DIV_FAST : asr_pkg::MOD_DIV_SLOW;

  // conversion completes on a modulator tick; held off while a frame is shifting
  assign fifo_pop = st_reg.mod_tick && (st_reg.link == asr_pkg::ASR_LINK_IDLE);
  assign conv_done = fifo_pop && fifo_valid;

  assign status_word = {asr_pkg::STATUS_PREFIX,
                        LEAD_OFF_STATUS_REGISTER[asr_pkg::LEAD_OFF_STATUS_REGISTER_MSB:0],
                        GPIO_LEVEL,
                        asr_pkg::STATUS_PAD};

  // ********************************
  // next state
  // ********************************
  always_comb begin
    st_next = st_reg;
    st_next.sclk_prev = SCLK;
    st_next.clk_pin_prev = CLK_PIN_I;
    st_next.rx_valid = 1'b0;
    st_next.mod_tick = 1'b0;

    // internal oscillator
    if (st_reg.osc_cnt == 6'(asr_pkg::OSC_HALF_CYC - 1)) begin
      st_next.osc_cnt = '0;
      st_next.osc_level = !st_reg.osc_level;
    end else begin
      st_next.osc_cnt = st_reg.osc_cnt + 1'b1;
    end

    // modulator divider
    if (dev_tick) begin
      if (st_reg.mod_cnt >= mod_div - 1'b1) begin
        st_next.mod_cnt = '0;
        st_next.mod_tick = 1'b1;
      end else begin
        st_next.mod_cnt = st_reg.mod_cnt + 1'b1;
      end
    end

    // reference control
    st_next.ref_buf_pd = !REF_BUFFER_ENABLE;
    st_next.ref_high = HIGH_REFERENCE_SELECT;

    // new frame
    if (conv_done) begin
      st_next.frame = {status_word, fifo_data};
    end

    // conversion-ready release on first falling edge, any chip select level
    if (sclk_fall && !st_reg.release_done) begin
      st_next.ready_n = 1'b1;
      st_next.release_done = 1'b1;
    end
    if (conv_done) begin
      st_next.ready_n = 1'b0;
      st_next.release_done = 1'b0;
    end

    if (FRAME_READ_CMD) begin
      st_next.single_armed = 1'b1;
    end

    if (CS_N) begin
      st_next.link = asr_pkg::ASR_LINK_IDLE;
      st_next.bit_ptr = '0;
      st_next.rx_cnt = '0;
      st_next.rx_shift = '0;
      st_next.dout = 1'b0;
      st_next.single_armed = (st_reg.link == asr_pkg::ASR_LINK_SHIFT) ? FRAME_READ_CMD :
                             (st_reg.single_armed || FRAME_READ_CMD);
    end else begin
      if (sclk_fall) begin
        st_next.rx_shift = {st_reg.rx_shift[6:0], DIN};
        st_next.rx_cnt = st_reg.rx_cnt + 1'b1;
        if (st_reg.rx_cnt == 3'h7) begin
          st_next.rx_byte = {st_reg.rx_shift[6:0], DIN};
          st_next.rx_valid = 1'b1;
        end
      end
      case (st_reg.link)
        asr_pkg::ASR_LINK_IDLE: begin
          if (!CONTINUOUS_READ_MODE && !st_reg.single_armed) begin
            st_next.dout = 1'b0;
          end else begin
            st_next.dout = st_reg.ready_n;
          end
          if (sclk_rise && (CONTINUOUS_READ_MODE || st_reg.single_armed)) begin
            st_next.link = asr_pkg::ASR_LINK_SHIFT;
            st_next.dout = st_reg.frame[FW-1];
            st_next.bit_ptr = 6'h01;
          end
        end
        asr_pkg::ASR_LINK_SHIFT: begin
          if (sclk_rise) begin
            st_next.dout = st_reg.frame[6'(FW - 1) - st_reg.bit_ptr];
            if (st_reg.bit_ptr == 6'(FW - 1)) begin
              st_next.bit_ptr = '0;
            end else begin
              st_next.bit_ptr = st_reg.bit_ptr + 1'b1;
            end
          end
        end
        default: begin
          st_next.link = asr_pkg::ASR_LINK_IDLE;
        end
      endcase
    end
  end

  // ********************************
  // state register
  // ********************************
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_reg <= '0;
      st_reg.link <= asr_pkg::ASR_LINK_IDLE;
      st_reg.ready_n <= asr_pkg::READY_N_RST;
      st_reg.release_done <= 1'b1;
      st_reg.ref_buf_pd <= asr_pkg::REF_BUF_PD_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign CLK_PIN_O = st_reg.osc_level;
  assign CLK_PIN_OE = CLOCK_SOURCE_SELECT_PIN && CLK_OUT_EN;
  assign MOD_CLK_TICK = st_reg.mod_tick;
  assign REFERENCE_BUFFER_POWER_DOWN = st_reg.ref_buf_pd;
  assign REF_HIGH_LEVEL = st_reg.ref_high;
  assign DOUT_O = st_reg.dout;
  assign DOUT_OE = !CS_N;
  assign CONVERSION_READY_N = st_reg.ready_n;
  assign RX_BYTE = st_reg.rx_byte;
  assign RX_BYTE_VALID = st_reg.rx_valid;

endmodule

`default_nettype wire
